// file: bench/token_node_monitor.sv
`timescale 1ns/1ps
module token_node_monitor
    import token_node_pkg::*;
(
    input wire logic              clock,         // bus clock
    input wire logic              resetn,        // async, active low
    input wire logic [ADDR_W-1:0] addr,          // offset
    input wire logic [DATA_W-1:0] wdata,         // write data
    input wire logic              wr,            // write strobe
    input wire logic              rd,            // read strobe
    input wire logic [DATA_W-1:0] rdata,         // read data
    input wire logic              hw_reset_in_n  // reset pin
);
    logic [7:0] cfg_q;
    logic [7:0] set_q;
    // shadow copies; pin reset restores defaults
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= CONFIG_RST;
            set_q <= FIRST_SETUP_REG_RST;
        end else if (!hw_reset_in_n) begin
            cfg_q <= CONFIG_RST;
            set_q <= FIRST_SETUP_REG_RST;
        end else if (wr && addr == ADDR_CONFIG) begin
            cfg_q <= wdata;
        end else if (wr && addr == ADDR_FIRST_SETUP_REG) begin
            set_q <= wdata;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_rd(logic [2:0] a);
        rd && addr == a;
    endsequence
    sequence s_soft;
        wr && addr == ADDR_CONFIG && wdata[CFG_SOFT_RESET];
    endsequence
    property p_one_strobe; !(wr && rd); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("wr and rd together");
    property p_idle_zero; !$past(rd) |-> rdata == 8'h00; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("rdata not zero");
    property p_cmd_zero; s_rd(ADDR_CMD) |=> rdata == 8'h00; endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("cmd read not zero");
    property p_cfg_keep; s_rd(ADDR_CONFIG) |=> rdata == $past(cfg_q); endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("config value lost");
    property p_set_keep; s_rd(ADDR_FIRST_SETUP_REG) |=> rdata == $past(set_q); endproperty
    a_set_keep: assert property (p_set_keep) else $error("setup value lost");
    property p_soft; s_soft ##2 s_rd(ADDR_STATION) |=> rdata == 8'h00; endproperty
    a_soft: assert property (p_soft) else $error("station kept in soft reset");
    property p_pulse; $fell(hw_reset_in_n) |=> !hw_reset_in_n [*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse short");
    property p_quiet; (wr || rd) |-> hw_reset_in_n; endproperty
    a_quiet: assert property (p_quiet) else $error("access during reset");
endmodule

// file: bench/token_node_reset_init_diag_tb.sv
`timescale 1ns/1ps
module token_node_reset_init_diag_tb;
    import token_node_pkg::*;
    logic              clock, resetn, reset_req, user_wr, user_rd, rx_line_in, user_ready;
    logic              user_rvalid, core_awake, tx_enable, tx_available_flag, refusal_irq, ram_wr;
    logic              own, reconfig_event_flag;
    logic [ADDR_W-1:0] user_addr;
    logic [7:0]        user_wdata, user_rdata, dest, next_in, ram_wdata, station;
    logic [6:0]        ev;
    logic [RAM_AW-1:0] ram_addr;
    logic [31:0]       seed;
    logic [18:0]       ramq[$];
    int                num_errors, samples_checked, n, reconfig_event_flag_n;
    token_node_if tif();
    token_node_host token_node_host_inst (.clock, .resetn, .bus(tif.host), .reset_req,
        .user_addr, .user_wdata, .user_wr, .user_rd, .user_ready, .user_rdata, .user_rvalid);
    token_node_device token_node_device_inst (.clock, .resetn, .bus(tif.device), .rx_line_in,
        .token_evt(ev[0]), .dest_station_field(dest), .token_own(own), .response_evt(ev[1]),
        .refusal_evt(ev[2]), .token_to_me_evt(ev[3]), .tx_request(ev[4]),
        .reconfig_event_flag_timer_evt(ev[5]), .next_load(ev[6]), .next_station_in(next_in), .core_awake,
        .tx_enable, .start_reconfig(reconfig_event_flag), .tx_available_flag, .refusal_irq, .ram_wr, .ram_addr,
        .ram_wdata);
    token_node_monitor token_node_monitor_inst (.clock, .resetn, .addr(tif.addr),
        .wdata(tif.wdata), .wr(tif.wr), .rd(tif.rd), .rdata(tif.rdata),
        .hw_reset_in_n(tif.hw_reset_in_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (num_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task rdy;
        for (n = 0; n < 200 && user_ready !== 1'b1; n++) @(posedge clock);
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        rdy();
        @(posedge clock);
        user_addr  <= a;
        user_wdata <= d;
        user_wr    <= 1'b1;
        @(posedge clock);
        user_wr <= 1'b0;
    endtask
    task rdc(input logic [2:0] a, input logic [7:0] e);
        rdy();
        @(posedge clock);
        user_addr <= a;
        user_rd   <= 1'b1;
        @(posedge clock);
        user_rd <= 1'b0;
        for (n = 0; n < 8 && user_rvalid !== 1'b1; n++) @(posedge clock);
        check(user_rdata, e);
    endtask
    task pulse(input logic [6:0] m);
        @(posedge clock);
        ev <= m;
        @(posedge clock);
        ev <= 7'h00;
        repeat (3) @(posedge clock);
    endtask
    // buffer writes must arrive in order, nothing extra
    always @(posedge clock) begin
        if (reconfig_event_flag === 1'b1) reconfig_event_flag_n++;
        if (ram_wr === 1'b1) begin
            if (ramq.size() == 0) check(1, 0);
            else check({ram_addr, ram_wdata}, ramq.pop_front());
        end
    end
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        conclude();
    end
    initial begin
        {resetn, reset_req, user_wr, user_rd, user_addr, user_wdata, rx_line_in} = '0;
        {ev, dest, next_in, num_errors, samples_checked, reconfig_event_flag_n, own} = '0;
        seed = 32'hE0333E95;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        wr(ADDR_FIRST_SETUP_REG, 8'h01);
        seed = xs(seed);
        station = seed[7:0] | 8'h01;
        ramq.push_back({RAM_ADDR_PATTERN, RAM_PATTERN});
        ramq.push_back({RAM_ADDR_STATION, station});
        check(core_awake, 0);
        wr(ADDR_STATION, station);
        repeat (5) @(posedge clock);
        check(core_awake, 1);
        check(ramq.size(), 0);
        seed = xs(seed);
        next_in <= seed[7:0] | 8'h01;
        pulse(7'h40);
        rdc(ADDR_NEXT, next_in);
        dest <= station;
        rx_line_in <= 1'b1;
        pulse(7'h01);
        rx_line_in <= 1'b0;
        pulse(7'h02);
        rdc(ADDR_DIAG, 8'h73);
        rdc(ADDR_DIAG, 8'h01);
        dest <= station ^ 8'h80;
        wr(ADDR_PROBE, station ^ 8'h80);
        pulse(7'h01);
        pulse(7'h02);
        rdc(ADDR_DIAG, 8'h15);
        own <= 1'b1;
        pulse(7'h01);
        own <= 1'b0;
        repeat (3) pulse(7'h04);
        check(refusal_irq, 0);
        pulse(7'h04);
        check(refusal_irq, 1);
        wr(ADDR_CMD, CMD_CLEAR_FLAGS);
        repeat (3) @(posedge clock);
        check(refusal_irq, 0);
        repeat (4) pulse(7'h04);
        check(refusal_irq, 1);
        pulse(7'h10);
        wr(ADDR_CMD, CMD_DISABLE_TX);
        repeat (3) @(posedge clock);
        check(tx_available_flag, 0);
        pulse(7'h08);
        check(tx_available_flag, 1);
        check(tx_enable, 0);
        wr(ADDR_CONFIG, 8'h20);
        repeat (3) @(posedge clock);
        check(tx_enable, 1);
        rdc(ADDR_DIAG, 8'h89);
        pulse(7'h20);
        rdc(ADDR_DIAG, 8'h89);
        wr(ADDR_CONFIG, 8'hA0);
        rdc(ADDR_STATION, 8'h00);
        rdc(ADDR_FIRST_SETUP_REG, 8'h01);
        check(core_awake, 0);
        check(tx_enable, 0);
        wr(ADDR_CONFIG, 8'h20);
        pulse(7'h10);
        @(posedge clock);
        reset_req <= 1'b1;
        @(posedge clock);
        reset_req <= 1'b0;
        repeat (4) @(posedge clock);
        rdc(ADDR_CONFIG, CONFIG_RST);
        check(tx_available_flag, 1);
        check(reconfig_event_flag_n, 2);
        conclude();
    end
endmodule

// file: core/token_node_device.sv
`timescale 1ns/1ps
module token_node_device
    import token_node_pkg::*;
(
    input  wire logic              clock,             // 40 MHz
    input  wire logic              resetn,            // async power-on reset
    token_node_if.device           bus,               // host bus and reset pin
    input  wire logic              rx_line_in,        // receive line pin
    input  wire logic              token_evt,         // token passed on the line
    input  wire logic [7:0]        dest_station_field,// destination of that token
    input  wire logic              token_own,         // token was sent by this node
    input  wire logic              response_evt,      // answer to the last token
    input  wire logic              refusal_evt,       // refusal to our buffer inquiry
    input  wire logic              token_to_me_evt,   // token arrived for this node
    input  wire logic              tx_request,        // transmission queued
    input  wire logic              reconfig_event_flag_timer_evt,   // token reception timer expired
    input  wire logic              next_load,         // next station learned
    input  wire logic [7:0]        next_station_in,   // its number
    output logic                   core_awake,        // microcode may run
    output logic                   tx_enable,         // transmitter allowed
    output logic                   start_reconfig,    // one-cycle reconfig request
    output logic                   tx_available_flag, // no transmission pending
    output logic                   refusal_irq,       // excessive refusal interrupt
    output logic                   ram_wr,            // buffer write strobe
    output logic [RAM_AW-1:0]      ram_addr,          // buffer address
    output logic [7:0]             ram_wdata          // buffer data
);
    typedef enum logic [1:0] {RAM_IDLE, RAM_PAT, RAM_ID} ram_state_t;

    logic [1:0] rst_sync_q, rx_sync_q;
    logic [7:0] rst_cnt_q, config_q, first_setup_reg_q, station_q, probe_q, next_q, last_dest_q;
    logic [7:0] rdata_q;
    logic [6:0] refusal_cnt_q;
    logic       hw_rst_q, bus_wr_odd_q, bus_known_q, probe_armed_q, abandon_q, joined_q;
    logic       self_reconfig_event_flag_q, dup_q, rx_act_q, token_seen_q, exc_q, probe_match_q, next_chg_q;
    logic       core_rst, wr_cmd, diag_rd, clear_cmd, refusal_hit;
    ram_state_t ram_state_q;
    function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
        return a == r;
    endfunction
    assign core_rst    = hw_rst_q | config_q[CFG_SOFT_RESET];
    assign wr_cmd      = bus.wr & hit(bus.addr, ADDR_CMD);
    assign diag_rd     = bus.rd & hit(bus.addr, ADDR_DIAG) & ~core_rst;
    assign clear_cmd   = wr_cmd & (bus.wdata == CMD_CLEAR_FLAGS);
    assign refusal_hit = refusal_evt & core_awake &
        ({1'b0, refusal_cnt_q} + 8'h01 ==
         (first_setup_reg_q[SET_SHORT_LIMIT] ? REFUSAL_LIMIT_SHORT : REFUSAL_LIMIT_LONG));

    // reset pin: glitches shorter than the minimum never reach the core
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'b00;    // pin taken as low: no early release after power-on
            rx_sync_q  <= 2'b00;
            rst_cnt_q  <= 8'h00;
            hw_rst_q   <= 1'b1;
        end else begin
            rst_sync_q <= {rst_sync_q[0], bus.hw_reset_in_n};
            rx_sync_q  <= {rx_sync_q[0], rx_line_in};
            if (rst_sync_q[1]) begin
                rst_cnt_q <= 8'h00;
                hw_rst_q  <= 1'b0;
            end else if (rst_cnt_q == RESET_MIN_CNT - 8'h01) begin
                hw_rst_q  <= 1'b1;
            end else begin
                rst_cnt_q <= rst_cnt_q + 8'h01;
            end
        end
    end

    // registers that survive a soft reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            config_q     <= CONFIG_RST;
            first_setup_reg_q     <= FIRST_SETUP_REG_RST;
            bus_wr_odd_q <= 1'b0;
            bus_known_q  <= 1'b0;
        end else if (hw_rst_q) begin
            config_q     <= CONFIG_RST;
            first_setup_reg_q     <= FIRST_SETUP_REG_RST;
            bus_wr_odd_q <= 1'b0;
            bus_known_q  <= 1'b0;
        end else begin
            if (bus.wr && hit(bus.addr, ADDR_CONFIG)) begin
                config_q <= bus.wdata;
            end
            if (bus.wr && hit(bus.addr, ADDR_FIRST_SETUP_REG)) begin
                first_setup_reg_q <= bus.wdata;
            end
            if (bus.wr && bus.addr[0]) begin
                bus_wr_odd_q <= 1'b1;
            end
            if (bus.rd && bus.addr[0] && bus_wr_odd_q) begin
                bus_known_q <= 1'b1;
            end
        end
    end

    // station, probe and next station
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {station_q, probe_q, next_q} <= {STATION_RST, PROBE_RST, NEXT_RST};
            {probe_armed_q, last_dest_q} <= 9'h000;
        end else if (core_rst) begin
            {station_q, probe_q, next_q} <= {STATION_RST, PROBE_RST, NEXT_RST};
            {probe_armed_q, last_dest_q} <= 9'h000;
        end else begin
            if (bus.wr && hit(bus.addr, ADDR_STATION)) begin
                station_q <= bus.wdata;
            end
            if (bus.wr && hit(bus.addr, ADDR_PROBE)) begin
                probe_q       <= bus.wdata;
                probe_armed_q <= 1'b1;
            end
            if (next_load) begin
                next_q <= next_station_in;
            end
            if (token_evt) begin
                last_dest_q <= dest_station_field;
            end
        end
    end

    // buffer self-write after each station number write seen in RAM_IDLE
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ram_state_q <= RAM_IDLE;
            ram_wr      <= 1'b0;
            ram_addr    <= RAM_ADDR_PATTERN;
            ram_wdata   <= 8'h00;
        end else if (core_rst) begin
            ram_state_q <= RAM_IDLE;
            ram_wr      <= 1'b0;
        end else begin
            ram_wr <= 1'b0;
            unique case (ram_state_q)
                RAM_IDLE: begin
                    if (bus.wr && hit(bus.addr, ADDR_STATION)) begin
                        ram_state_q <= RAM_PAT;
                    end
                end
                RAM_PAT: begin
                    ram_wr      <= 1'b1;
                    ram_addr    <= RAM_ADDR_PATTERN;
                    ram_wdata   <= RAM_PATTERN;
                    ram_state_q <= RAM_ID;
                end
                RAM_ID: begin
                    ram_wr      <= 1'b1;
                    ram_addr    <= RAM_ADDR_STATION;
                    ram_wdata   <= station_q;
                    ram_state_q <= RAM_IDLE;
                end
            endcase
        end
    end

    // wake, join and reconfiguration
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {core_awake, joined_q, tx_enable, start_reconfig} <= 4'h0;
        end else if (core_rst) begin
            {core_awake, joined_q, tx_enable, start_reconfig} <= 4'h0;
        end else begin
            core_awake     <= station_q != 8'h00;
            joined_q       <= core_awake & config_q[CFG_JOIN_ENABLE];
            tx_enable      <= core_awake & config_q[CFG_JOIN_ENABLE];
            start_reconfig <= core_awake &
                ((config_q[CFG_JOIN_ENABLE] & ~joined_q) |
                 (reconfig_event_flag_timer_evt & joined_q));
        end
    end

    // sticky diagnostic flags; a set in the clearing cycle wins
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {self_reconfig_event_flag_q, dup_q, rx_act_q, token_seen_q, probe_match_q, next_chg_q} <= 6'h00;
        end else if (core_rst) begin
            {self_reconfig_event_flag_q, dup_q, rx_act_q, token_seen_q, probe_match_q, next_chg_q} <= 6'h00;
        end else begin
            self_reconfig_event_flag_q  <= (self_reconfig_event_flag_q & ~diag_rd) | start_reconfig;
            dup_q         <= (dup_q & ~diag_rd) |
                (response_evt & core_awake & last_dest_q == station_q);
            rx_act_q      <= (rx_act_q & ~diag_rd) | rx_sync_q[1];
            token_seen_q  <= (token_seen_q & ~diag_rd) | (token_evt & ~token_own);
            probe_match_q <= (probe_match_q & ~diag_rd) |
                (response_evt & probe_armed_q & last_dest_q == probe_q);
            next_chg_q    <= (next_chg_q & ~diag_rd) |
                (next_load & next_station_in != next_q);
        end
    end

    // refusal counting and transmitter availability
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            refusal_cnt_q <= 7'h00;
            {exc_q, refusal_irq, abandon_q, tx_available_flag} <= 4'h1;
        end else if (core_rst) begin
            refusal_cnt_q <= 7'h00;
            {exc_q, refusal_irq, abandon_q, tx_available_flag} <= 4'h1;
        end else begin
            if (refusal_evt && core_awake) begin
                refusal_cnt_q <= refusal_hit ? 7'h00 : refusal_cnt_q + 7'h01;
            end
            exc_q       <= (exc_q & ~clear_cmd) | refusal_hit;
            refusal_irq <= (exc_q & ~clear_cmd) | refusal_hit;
            if (wr_cmd && bus.wdata == CMD_DISABLE_TX) begin
                abandon_q <= 1'b1;
            end else if (token_to_me_evt && abandon_q) begin
                abandon_q <= 1'b0;
            end
            if (tx_request) begin
                tx_available_flag <= 1'b0;
            end else if (token_to_me_evt && abandon_q) begin
                tx_available_flag <= 1'b1;
            end
        end
    end

    // read data, valid in the cycle after the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (!bus.rd) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (bus.addr)
                ADDR_DIAG:    rdata_q <= {self_reconfig_event_flag_q, dup_q, rx_act_q, token_seen_q,
                                          exc_q, probe_match_q, next_chg_q, core_awake};
                ADDR_CONFIG:  rdata_q <= config_q;
                ADDR_FIRST_SETUP_REG:  rdata_q <= first_setup_reg_q;
                ADDR_STATION: rdata_q <= station_q;
                ADDR_PROBE:   rdata_q <= probe_q;
                ADDR_NEXT:    rdata_q <= next_q;
                ADDR_STATUS:  rdata_q <= {5'h00, joined_q, bus_known_q, tx_available_flag};
                ADDR_CMD:     rdata_q <= 8'h00;
            endcase
        end
    end

    assign bus.rdata = rdata_q;
endmodule

// file: core/token_node_host.sv
`timescale 1ns/1ps
module token_node_host
    import token_node_pkg::*;
(
    input  wire logic              clock,        // 40 MHz
    input  wire logic              resetn,       // async, active low
    token_node_if.host             bus,          // device bus and reset pin
    input  wire logic              reset_req,    // pulse: reset the device
    input  wire logic [ADDR_W-1:0] user_addr,    // register offset
    input  wire logic [DATA_W-1:0] user_wdata,   // write data
    input  wire logic              user_wr,      // write strobe
    input  wire logic              user_rd,      // read strobe
    output logic                   user_ready,   // strobes accepted
    output logic [DATA_W-1:0]      user_rdata,   // read data
    output logic                   user_rvalid   // pulse with read data
);
    typedef enum logic [1:0] {H_RESET, H_PROBE_WR, H_PROBE_RD, H_READY} host_state_t;

    host_state_t state_q;
    logic [7:0]  cnt_q;
    logic        rd_pend_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic        wr_q;
    logic        rd_q;
    logic        rst_n_q;

    // pulse held a little longer than the device filter needs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q    <= H_RESET;
            cnt_q      <= 8'h00;
            rst_n_q    <= 1'b0;
            addr_q     <= '0;
            wdata_q    <= '0;
            wr_q       <= 1'b0;
            rd_q       <= 1'b0;
            user_ready <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (reset_req) begin
                state_q    <= H_RESET;
                cnt_q      <= 8'h00;
                rst_n_q    <= 1'b0;
                user_ready <= 1'b0;
            end else begin
                unique case (state_q)
                    H_RESET: begin
                        if (cnt_q == RESET_MIN_CNT + 8'h04) begin
                            rst_n_q <= 1'b1;
                            state_q <= H_PROBE_WR;
                            cnt_q   <= 8'h00;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    H_PROBE_WR: begin
                        // waits out the device's pin synchroniser before the first access
                        if (cnt_q == 8'h04) begin
                            wr_q    <= 1'b1;
                            addr_q  <= ADDR_FIRST_SETUP_REG;
                            wdata_q <= FIRST_SETUP_REG_RST;
                            state_q <= H_PROBE_RD;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    H_PROBE_RD: begin
                        rd_q       <= 1'b1;
                        addr_q     <= ADDR_FIRST_SETUP_REG;
                        state_q    <= H_READY;
                        user_ready <= 1'b1;
                    end
                    H_READY: begin
                        wr_q    <= user_wr;
                        rd_q    <= user_rd & ~user_wr;
                        addr_q  <= user_addr;
                        wdata_q <= user_wdata;
                    end
                endcase
            end
        end
    end

    // answers to user reads; the probe read also raises user_rvalid, since state_q is already H_READY
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_pend_q   <= 1'b0;
            user_rdata  <= '0;
            user_rvalid <= 1'b0;
        end else begin
            rd_pend_q   <= rd_q & (state_q == H_READY);
            user_rvalid <= rd_pend_q;
            if (rd_pend_q) begin
                user_rdata <= bus.rdata;
            end
        end
    end

    assign bus.addr          = addr_q;
    assign bus.wdata         = wdata_q;
    assign bus.wr            = wr_q;
    assign bus.rd            = rd_q;
    assign bus.hw_reset_in_n = rst_n_q;
endmodule

// file: inc/token_node_if.sv
`timescale 1ns/1ps
interface token_node_if;
    import token_node_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              hw_reset_in_n;

    modport device (input addr, input wdata, input wr, input rd, output rdata,
                    input hw_reset_in_n);
    modport host (output addr, output wdata, output wr, output rd, input rdata,
                  output hw_reset_in_n);
endinterface

// file: inc/token_node_pkg.sv
package token_node_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int RAM_AW = 11;

    // register offsets
    localparam logic [2:0] ADDR_CMD     = 3'h0;
    localparam logic [2:0] ADDR_DIAG    = 3'h1;
    localparam logic [2:0] ADDR_CONFIG  = 3'h2;
    localparam logic [2:0] ADDR_FIRST_SETUP_REG  = 3'h3;
    localparam logic [2:0] ADDR_STATION = 3'h4;
    localparam logic [2:0] ADDR_PROBE   = 3'h5;
    localparam logic [2:0] ADDR_NEXT    = 3'h6;
    localparam logic [2:0] ADDR_STATUS  = 3'h7;

    // field positions
    localparam int CFG_SOFT_RESET   = 7;
    localparam int CFG_JOIN_ENABLE  = 5;
    localparam int SET_SHORT_LIMIT  = 0;
    localparam int SET_TSEL_A       = 1;
    localparam int SET_TSEL_B       = 2;
    localparam int DIAG_SELF_RECONFIG_EVENT_FLAG  = 7;
    localparam int DIAG_DUPLICATE   = 6;
    localparam int DIAG_RX_ACTIVITY = 5;
    localparam int DIAG_TOKEN_SEEN  = 4;
    localparam int DIAG_EXC_REFUSAL = 3;
    localparam int DIAG_PROBE_MATCH = 2;
    localparam int DIAG_NEXT_CHANGE = 1;
    localparam int DIAG_AWAKE       = 0;
    localparam int STAT_TX_AVAIL    = 0;
    localparam int STAT_BUS_KNOWN   = 1;
    localparam int STAT_JOINED      = 2;

    // reset values
    localparam logic [7:0] CONFIG_RST  = 8'h00;
    localparam logic [7:0] FIRST_SETUP_REG_RST  = 8'h00;
    localparam logic [7:0] STATION_RST = 8'h00;
    localparam logic [7:0] PROBE_RST   = 8'h00;
    localparam logic [7:0] NEXT_RST    = 8'h00;

    // commands
    localparam logic [7:0] CMD_DISABLE_TX  = 8'h01;
    localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h1E;

    // buffer self-write
    localparam logic [7:0]        RAM_PATTERN      = 8'hD1;
    localparam logic [RAM_AW-1:0] RAM_ADDR_PATTERN = 11'h000;
    localparam logic [RAM_AW-1:0] RAM_ADDR_STATION = 11'h001;

    // refusal limits
    localparam logic [7:0] REFUSAL_LIMIT_LONG  = 8'h80;
    localparam logic [7:0] REFUSAL_LIMIT_SHORT = 8'h04;

    // timing
    localparam int CLOCK_PERIOD_NS   = 25;
    localparam int CRYSTAL_PERIOD_NS = 50;
    localparam int RESET_MIN_PERIODS = 5;
    localparam int RESET_MIN_CYCLES  =
        (RESET_MIN_PERIODS * CRYSTAL_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [7:0] RESET_MIN_CNT = RESET_MIN_CYCLES[7:0];
endpackage
